// [ivp_pkg.sv]
package ivp_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VEC_W = 16;
  localparam int LVL_W = 2;
  localparam int NSRC = 31;
  localparam int IDX_W = 5;

  // ---------------------------------------------------------------
  // priority levels
  // ---------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_NMI = 2'h3;
  localparam logic [LVL_W-1:0] LVL_MAX_MASKABLE = 2'h2;

  // ---------------------------------------------------------------
  // source indices, listed from highest to lowest fixed rank
  // ---------------------------------------------------------------
  localparam int NUM_CORE = 6;
  localparam logic [IDX_W-1:0] SRC_RESET = 5'h00;
  localparam logic [IDX_W-1:0] SRC_STACK_ERR = 5'h01;
  localparam logic [IDX_W-1:0] SRC_ILLEGAL = 5'h02;
  localparam logic [IDX_W-1:0] SRC_DEBUG = 5'h03;
  localparam logic [IDX_W-1:0] SRC_TRAP = 5'h04;
  localparam logic [IDX_W-1:0] SRC_NMI = 5'h05;
  localparam logic [IDX_W-1:0] SRC_EXT_A = 5'h06;
  localparam logic [IDX_W-1:0] SRC_EXT_B = 5'h07;
  localparam logic [IDX_W-1:0] SRC_EXT_C = 5'h08;
  localparam logic [IDX_W-1:0] SRC_EXT_D = 5'h09;
  localparam logic [IDX_W-1:0] SRC_HOST_CMD = 5'h0a;
  localparam logic [IDX_W-1:0] SRC_HOST_TX = 5'h0b;
  localparam logic [IDX_W-1:0] SRC_HOST_RX = 5'h0c;
  localparam logic [IDX_W-1:0] SRC_SP0_RXE = 5'h0d;
  localparam logic [IDX_W-1:0] SRC_SP0_RX = 5'h0e;
  localparam logic [IDX_W-1:0] SRC_SP0_RXL = 5'h0f;
  localparam logic [IDX_W-1:0] SRC_SP0_TXE = 5'h10;
  localparam logic [IDX_W-1:0] SRC_SP0_TXL = 5'h11;
  localparam logic [IDX_W-1:0] SRC_SP0_TX = 5'h12;
  localparam logic [IDX_W-1:0] SRC_SP1_RXE = 5'h13;
  localparam logic [IDX_W-1:0] SRC_SP1_RX = 5'h14;
  localparam logic [IDX_W-1:0] SRC_SP1_RXL = 5'h15;
  localparam logic [IDX_W-1:0] SRC_SP1_TXE = 5'h16;
  localparam logic [IDX_W-1:0] SRC_SP1_TXL = 5'h17;
  localparam logic [IDX_W-1:0] SRC_SP1_TX = 5'h18;
  localparam logic [IDX_W-1:0] SRC_T0_OVF = 5'h19;
  localparam logic [IDX_W-1:0] SRC_T0_CMP = 5'h1a;
  localparam logic [IDX_W-1:0] SRC_T1_OVF = 5'h1b;
  localparam logic [IDX_W-1:0] SRC_T1_CMP = 5'h1c;
  localparam logic [IDX_W-1:0] SRC_T2_OVF = 5'h1d;
  localparam logic [IDX_W-1:0] SRC_T2_CMP = 5'h1e;

  // ---------------------------------------------------------------
  // vector offsets from the vector base
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] OFS_RESET = 16'h0000;
  localparam logic [VEC_W-1:0] OFS_STACK_ERR = 16'h0002;
  localparam logic [VEC_W-1:0] OFS_ILLEGAL = 16'h0004;
  localparam logic [VEC_W-1:0] OFS_DEBUG = 16'h0006;
  localparam logic [VEC_W-1:0] OFS_TRAP = 16'h0008;
  localparam logic [VEC_W-1:0] OFS_NMI = 16'h000a;
  localparam logic [VEC_W-1:0] OFS_EXT_A = 16'h0010;
  localparam logic [VEC_W-1:0] OFS_EXT_B = 16'h0012;
  localparam logic [VEC_W-1:0] OFS_EXT_C = 16'h0014;
  localparam logic [VEC_W-1:0] OFS_EXT_D = 16'h0016;
  localparam logic [VEC_W-1:0] OFS_T0_CMP = 16'h0024;
  localparam logic [VEC_W-1:0] OFS_T0_OVF = 16'h0026;
  localparam logic [VEC_W-1:0] OFS_T1_CMP = 16'h0028;
  localparam logic [VEC_W-1:0] OFS_T1_OVF = 16'h002a;
  localparam logic [VEC_W-1:0] OFS_T2_CMP = 16'h002c;
  localparam logic [VEC_W-1:0] OFS_T2_OVF = 16'h002e;
  localparam logic [VEC_W-1:0] OFS_SP0_RX = 16'h0030;
  localparam logic [VEC_W-1:0] OFS_SP0_RXE = 16'h0032;
  localparam logic [VEC_W-1:0] OFS_SP0_RXL = 16'h0034;
  localparam logic [VEC_W-1:0] OFS_SP0_TX = 16'h0036;
  localparam logic [VEC_W-1:0] OFS_SP0_TXE = 16'h0038;
  localparam logic [VEC_W-1:0] OFS_SP0_TXL = 16'h003a;
  localparam logic [VEC_W-1:0] OFS_SP1_RX = 16'h0040;
  localparam logic [VEC_W-1:0] OFS_SP1_RXE = 16'h0042;
  localparam logic [VEC_W-1:0] OFS_SP1_RXL = 16'h0044;
  localparam logic [VEC_W-1:0] OFS_SP1_TX = 16'h0046;
  localparam logic [VEC_W-1:0] OFS_SP1_TXE = 16'h0048;
  localparam logic [VEC_W-1:0] OFS_SP1_TXL = 16'h004a;
  localparam logic [VEC_W-1:0] OFS_HOST_RX = 16'h0060;
  localparam logic [VEC_W-1:0] OFS_HOST_TX = 16'h0062;
  localparam logic [VEC_W-1:0] OFS_HOST_CMD = 16'h0064;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_RST = 16'h0000;
  localparam logic [IDX_W-1:0] IDX_RST = 5'h00;

endpackage

// [ivp_level_pick.sv]
`timescale 1ns/10ps
// fixed-order finder: lowest index among candidates wins
module ivp_level_pick
  import ivp_pkg::*;
#(
  parameter int N = NSRC
)
(
  input wire logic [N-1:0] cand_i,
  output logic found_o,
  output logic [IDX_W-1:0] idx_o
);

  // ---------------------------------------------------------------
  // priority scan
  // ---------------------------------------------------------------
  // scan downwards so the lowest index is the last and final winner
  always_comb
  begin
    found_o = 1'b0;
    idx_o = IDX_RST;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (cand_i[i])
      begin
        found_o = 1'b1;
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule

// [ivp_top.sv]
`timescale 1ns/10ps
// Functional notes
// - nonmaskable order: reset, stack error, illegal, debug, trap, nmi last
// - external and peripheral sources maskable, levels zero to two only
// - port 0 receive vectors: base+30, +32 exception, +34 last slot
// - port 0 transmit vectors: base+36, +38 exception, +3a last slot
// - port 1 receive vectors: base+40, +42 exception, +44 last slot
// - port 1 transmit vectors: base+46, +48 exception
// - host vectors: receive full +60, transmit empty +62, command +64
// - within level: requests a,b,c,d, then host command, transmit, receive
// - port 0 below host: rxe, rx, rxl, txe, txl, tx
// - port 1 below port 0; receive order rxe, rx, rxl
// - port 1 transmit after receive: txe, txl, tx
// - timers lowest, 0 then 1 then 2, overflow above compare
module ivp_top
  import ivp_pkg::*;
#(
  parameter int VW = VEC_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [VW-1:0] vector_base_i,
  input wire logic [NUM_CORE-1:0] core_req_i,
  input wire logic external_request_a_i,
  input wire logic external_request_b_i,
  input wire logic external_request_c_i,
  input wire logic external_request_d_i,
  input wire logic [LVL_W*4-1:0] ext_level_i,
  input wire logic [3:0] ext_enable_i,
  input wire logic [2:0] host_req_i,
  input wire logic [5:0] serial_port_0_req_i,
  input wire logic [5:0] serial_port_1_req_i,
  input wire logic [5:0] timer_req_i,
  input wire logic [NSRC-NUM_CORE-4-1:0] periph_enable_i,
  input wire logic [LVL_W*(NSRC-NUM_CORE-4)-1:0] periph_level_i,
  input wire logic [LVL_W-1:0] interrupt_priority_level_i,
  input wire logic ack_i,
  output logic irq_valid_o,
  output logic [VW-1:0] vector_o,
  output logic [IDX_W-1:0] source_o,
  output logic [LVL_W-1:0] level_o
);

  // ---------------------------------------------------------------
  // source packing
  // ---------------------------------------------------------------
  localparam int NPER = NSRC - NUM_CORE - 4;

  logic [3:0] ext_s1_r;
  logic [3:0] ext_s2_r;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] enable;
  logic [LVL_W-1:0] lvl [NSRC];
  logic [NSRC-1:0] cand;
  logic [LVL_W-1:0] win_lvl;
  logic any_req;
  logic found;
  logic [IDX_W-1:0] win_idx;
  logic [VW-1:0] vector_nxt;

  // external lines come from pins, so two stages before any use
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
    end
    else if (ce_i)
    begin
      ext_s1_r <= {external_request_d_i, external_request_c_i,
                   external_request_b_i, external_request_a_i};
      ext_s2_r <= ext_s1_r;
    end
  end

  // request vector in fixed rank order; index 0 is the strongest
  always_comb
  begin
    req = '0;
    req[SRC_RESET] = core_req_i[0];
    req[SRC_STACK_ERR] = core_req_i[1];
    req[SRC_ILLEGAL] = core_req_i[2];
    req[SRC_DEBUG] = core_req_i[3];
    req[SRC_TRAP] = core_req_i[4];
    req[SRC_NMI] = core_req_i[5];
    req[SRC_EXT_A] = ext_s2_r[0];
    req[SRC_EXT_B] = ext_s2_r[1];
    req[SRC_EXT_C] = ext_s2_r[2];
    req[SRC_EXT_D] = ext_s2_r[3];
    req[SRC_HOST_CMD] = host_req_i[2];
    req[SRC_HOST_TX] = host_req_i[1];
    req[SRC_HOST_RX] = host_req_i[0];
    req[SRC_SP0_RXE] = serial_port_0_req_i[1];
    req[SRC_SP0_RX] = serial_port_0_req_i[0];
    req[SRC_SP0_RXL] = serial_port_0_req_i[2];
    req[SRC_SP0_TXE] = serial_port_0_req_i[4];
    req[SRC_SP0_TXL] = serial_port_0_req_i[5];
    req[SRC_SP0_TX] = serial_port_0_req_i[3];
    req[SRC_SP1_RXE] = serial_port_1_req_i[1];
    req[SRC_SP1_RX] = serial_port_1_req_i[0];
    req[SRC_SP1_RXL] = serial_port_1_req_i[2];
    req[SRC_SP1_TXE] = serial_port_1_req_i[4];
    req[SRC_SP1_TXL] = serial_port_1_req_i[5];
    req[SRC_SP1_TX] = serial_port_1_req_i[3];
    req[SRC_T0_OVF] = timer_req_i[1];
    req[SRC_T0_CMP] = timer_req_i[0];
    req[SRC_T1_OVF] = timer_req_i[3];
    req[SRC_T1_CMP] = timer_req_i[2];
    req[SRC_T2_OVF] = timer_req_i[5];
    req[SRC_T2_CMP] = timer_req_i[4];
  end

  // ---------------------------------------------------------------
  // masking and level assignment
  // ---------------------------------------------------------------
  // clamp keeps a maskable source off the nonmaskable level
  function automatic logic [LVL_W-1:0] clamp_lvl(input logic [LVL_W-1:0] l);
    clamp_lvl = (l > LVL_MAX_MASKABLE) ? LVL_MAX_MASKABLE : l;
  endfunction

  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      enable[i] = 1'b1;
      lvl[i] = LVL_NMI;
    end
    for (int i = 0; i < 4; i++)
    begin
      enable[NUM_CORE + i] = ext_enable_i[i];
      lvl[NUM_CORE + i] = clamp_lvl(ext_level_i[i*LVL_W +: LVL_W]);
    end
    for (int i = 0; i < NPER; i++)
    begin
      enable[NUM_CORE + 4 + i] = periph_enable_i[i];
      lvl[NUM_CORE + 4 + i] = clamp_lvl(periph_level_i[i*LVL_W +: LVL_W]);
    end
  end

  // ---------------------------------------------------------------
  // level selection then fixed order
  // ---------------------------------------------------------------
  // level 3 always passes; a maskable source must reach the core's level
  always_comb
  begin
    win_lvl = '0;
    any_req = 1'b0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (req[i] && enable[i] &&
          (lvl[i] == LVL_NMI || lvl[i] >= interrupt_priority_level_i))
      begin
        any_req = 1'b1;
        if (lvl[i] > win_lvl)
        begin
          win_lvl = lvl[i];
        end
      end
    end
    for (int i = 0; i < NSRC; i++)
    begin
      cand[i] = any_req && req[i] && enable[i] && (lvl[i] == win_lvl);
    end
  end

  ivp_level_pick #(
    .N(NSRC)
  ) u_pick (
    .cand_i(cand),
    .found_o(found),
    .idx_o(win_idx)
  );

  // ---------------------------------------------------------------
  // vector formation
  // ---------------------------------------------------------------
  function automatic logic [VEC_W-1:0] src_ofs(input logic [IDX_W-1:0] s);
    case (s)
      SRC_RESET: src_ofs = OFS_RESET;
      SRC_STACK_ERR: src_ofs = OFS_STACK_ERR;
      SRC_ILLEGAL: src_ofs = OFS_ILLEGAL;
      SRC_DEBUG: src_ofs = OFS_DEBUG;
      SRC_TRAP: src_ofs = OFS_TRAP;
      SRC_NMI: src_ofs = OFS_NMI;
      SRC_EXT_A: src_ofs = OFS_EXT_A;
      SRC_EXT_B: src_ofs = OFS_EXT_B;
      SRC_EXT_C: src_ofs = OFS_EXT_C;
      SRC_EXT_D: src_ofs = OFS_EXT_D;
      SRC_HOST_CMD: src_ofs = OFS_HOST_CMD;
      SRC_HOST_TX: src_ofs = OFS_HOST_TX;
      SRC_HOST_RX: src_ofs = OFS_HOST_RX;
      SRC_SP0_RXE: src_ofs = OFS_SP0_RXE;
      SRC_SP0_RX: src_ofs = OFS_SP0_RX;
      SRC_SP0_RXL: src_ofs = OFS_SP0_RXL;
      SRC_SP0_TXE: src_ofs = OFS_SP0_TXE;
      SRC_SP0_TXL: src_ofs = OFS_SP0_TXL;
      SRC_SP0_TX: src_ofs = OFS_SP0_TX;
      SRC_SP1_RXE: src_ofs = OFS_SP1_RXE;
      SRC_SP1_RX: src_ofs = OFS_SP1_RX;
      SRC_SP1_RXL: src_ofs = OFS_SP1_RXL;
      SRC_SP1_TXE: src_ofs = OFS_SP1_TXE;
      SRC_SP1_TXL: src_ofs = OFS_SP1_TXL;
      SRC_SP1_TX: src_ofs = OFS_SP1_TX;
      SRC_T0_OVF: src_ofs = OFS_T0_OVF;
      SRC_T0_CMP: src_ofs = OFS_T0_CMP;
      SRC_T1_OVF: src_ofs = OFS_T1_OVF;
      SRC_T1_CMP: src_ofs = OFS_T1_CMP;
      SRC_T2_OVF: src_ofs = OFS_T2_OVF;
      SRC_T2_CMP: src_ofs = OFS_T2_CMP;
      default: src_ofs = OFS_RESET;
    endcase
  endfunction

  // wraps modulo the vector width, as a plain address adder would
  assign vector_nxt = VW'(vector_base_i + VW'(src_ofs(win_idx)));

  // ---------------------------------------------------------------
  // registered answer to program control
  // ---------------------------------------------------------------
  // ack drops the valid for one cycle so the core sees a fresh decision
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_valid_o <= 1'b0;
      vector_o <= VEC_RST;
      source_o <= IDX_RST;
      level_o <= '0;
    end
    else if (ce_i)
    begin
      irq_valid_o <= found && !ack_i;
      if (found)
      begin
        vector_o <= vector_nxt;
        source_o <= win_idx;
        level_o <= win_lvl;
      end
    end
  end

endmodule

// [ivp_top_chk_asserts.sv]
`timescale 1ns/10ps
module ivp_top_chk
  import ivp_pkg::*;
#(
  parameter int VW = VEC_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [VW-1:0] vector_base_i,
  input wire logic [NUM_CORE-1:0] core_req_i,
  input wire logic [LVL_W-1:0] interrupt_priority_level_i,
  input wire logic ack_i,
  input wire logic irq_valid_o,
  input wire logic [VW-1:0] vector_o,
  input wire logic [IDX_W-1:0] source_o,
  input wire logic [LVL_W-1:0] level_o
);
  // ------------------------------------------------------------
  // output relations, one edge behind the sampled inputs
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fresh decision: enabled last edge, so outputs follow last inputs
  sequence s_fresh;
    irq_valid_o && $past(ce_i);
  endsequence
  sequence s_took;
    ce_i && ack_i;
  endsequence
  sequence s_core;
    ce_i && !ack_i && (core_req_i != 6'h00);
  endsequence
  property p_reset_first;
    s_core ##0 core_req_i[0] |=> irq_valid_o && source_o == SRC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset not first");
  property p_nmi_last;
    s_core ##0 core_req_i == 6'h20 |=> source_o == SRC_NMI && level_o == LVL_NMI;
  endproperty
  a_nmi_last: assert property (p_nmi_last) else $error("nmi not served");
  property p_core_top;
    s_core |=> irq_valid_o && level_o == LVL_NMI && source_o < SRC_EXT_A;
  endproperty
  a_core_top: assert property (p_core_top) else $error("core level lost");
  property p_mask_level;
    s_fresh |-> (source_o < SRC_EXT_A) == (level_o == LVL_NMI);
  endproperty
  a_mask_level: assert property (p_mask_level) else $error("bad source level");
  property p_ipl;
    s_fresh |-> level_o >= $past(interrupt_priority_level_i);
  endproperty
  a_ipl: assert property (p_ipl) else $error("masked level won");
  property p_even;
    s_fresh ##0 source_o == SRC_RESET |-> vector_o == $past(vector_base_i);
  endproperty
  a_even: assert property (p_even) else $error("reset vector off base");
  property p_sp0_rx;
    s_fresh ##0 source_o == SRC_SP0_RX |-> vector_o == $past(vector_base_i) + 16'h0030;
  endproperty
  a_sp0_rx: assert property (p_sp0_rx) else $error("port 0 rx vector");
  property p_host_cmd;
    s_fresh ##0 source_o == SRC_HOST_CMD |-> vector_o == $past(vector_base_i) + 16'h0064;
  endproperty
  a_host_cmd: assert property (p_host_cmd) else $error("host cmd vector");
  property p_ack_drop;
    s_took |=> !irq_valid_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("valid after ack");
  property p_freeze;
    !ce_i |=> $stable(vector_o) && $stable(source_o) && $stable(irq_valid_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while held");
endmodule

bind ivp_top ivp_top_chk #(.VW(VW)) ivp_top_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .vector_base_i(vector_base_i),
  .core_req_i(core_req_i), .interrupt_priority_level_i(interrupt_priority_level_i),
  .ack_i(ack_i), .irq_valid_o(irq_valid_o), .vector_o(vector_o),
  .source_o(source_o), .level_o(level_o));

// [ivp_core_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// program control stand-in: takes an offered vector after a wait
// ------------------------------------------------------------
module ivp_core_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_valid_i,
  input wire logic take_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic pend_r;
  logic [3:0] wait_r;
  // acks only while a vector is offered, so an idle block is never acked
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_r <= 1'b0;
      wait_r <= 4'h0;
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= 1'b0;
      if (take_i)
      begin
        pend_r <= 1'b1;
        wait_r <= delay_i;
      end
      else if (pend_r && irq_valid_i && wait_r == 4'h0)
      begin
        ack_o <= 1'b1;
        pend_r <= 1'b0;
      end
      else if (pend_r && irq_valid_i)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule

// [interrupt_vector_priority_bench.sv]
`timescale 1ns/10ps
module interrupt_vector_priority_bench;
  import ivp_pkg::*;
  // ------------------------------------------------------------
  // stimulus, driven on the falling edge
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [15:0] base = 16'h0000;
  logic [5:0] core = 6'h00;
  logic [24:0] rq = 25'h0000000; // rank order, bit 0 is line a
  logic [7:0] ext_lvl = 8'haa;
  logic [3:0] ext_en = 4'hf;
  logic [20:0] per_en = 21'h1fffff;
  logic [41:0] per_lvl = 42'h2aaaaaaaaaa;
  logic [1:0] interrupt_priority_level = 2'h0;
  logic take = 1'b0;
  logic [3:0] dly = 4'h0;
  logic ack;
  logic valid;
  logic [15:0] vec;
  logic [4:0] src;
  logic [1:0] lvl;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] ofs_tab [0:24] = '{16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0064,
    16'h0062, 16'h0060, 16'h0032, 16'h0030, 16'h0034, 16'h0038, 16'h003a, 16'h0036,
    16'h0042, 16'h0040, 16'h0044, 16'h0048, 16'h004a, 16'h0046, 16'h0026, 16'h0024,
    16'h002a, 16'h0028, 16'h002e, 16'h002c};
  ivp_top ivp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .vector_base_i(base),
    .core_req_i(core), .external_request_a_i(rq[0]), .external_request_b_i(rq[1]),
    .external_request_c_i(rq[2]), .external_request_d_i(rq[3]), .ext_level_i(ext_lvl),
    .ext_enable_i(ext_en), .host_req_i({rq[4], rq[5], rq[6]}),
    .serial_port_0_req_i({rq[11], rq[10], rq[12], rq[9], rq[7], rq[8]}),
    .serial_port_1_req_i({rq[17], rq[16], rq[18], rq[15], rq[13], rq[14]}),
    .timer_req_i({rq[23], rq[24], rq[21], rq[22], rq[19], rq[20]}),
    .periph_enable_i(per_en), .periph_level_i(per_lvl),
    .interrupt_priority_level_i(interrupt_priority_level), .ack_i(ack), .irq_valid_o(valid),
    .vector_o(vec), .source_o(src), .level_o(lvl));
  ivp_core_model ivp_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_valid_i(valid),
    .take_i(take), .delay_i(dly), .ack_o(ack));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // a hang ends in the same report as a normal run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task win(input logic [4:0] s, input logic [15:0] o, input logic [1:0] l);
    chk({15'h0000, valid}, 16'h0001);
    chk({11'h000, src}, {11'h000, s});
    chk(vec, base + o);
    chk({14'h0000, lvl}, {14'h0000, l});
  endtask
  // the far side takes the vector; the next cycle must show no request
  task take_vec(input logic [3:0] d);
    int n;
    dly = d;
    take = 1'b1;
    cyc_n(1);
    take = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 20)
    begin
      cyc_n(1);
      n++;
    end
    chk({15'h0000, ack}, 16'h0001);
    cyc_n(1);
    chk({15'h0000, valid}, 16'h0000);
  endtask
  // core exceptions beat every maskable request, then drop off one by one
  task t_core_order;
    base = 16'h8000;
    rq = 25'h1ffffff;
    for (int i = 0; i < 6; i++)
    begin
      core = 6'h3f << i;
      cyc_n(1);
      win(5'(i), 16'(2 * i), LVL_NMI);
    end
    core = 6'h00;
    rq = 25'h0000000;
    cyc_n(4);
  endtask
  // everything pending on one level: served strictly in fixed rank
  task t_rank;
    base = 16'h1200;
    rq = 25'h1ffffff;
    cyc_n(4);
    for (int k = 0; k < 25; k++)
    begin
      win(5'(k + 6), ofs_tab[k], 2'h2);
      // the line stays up until the core has taken it, so the ack can come
      take_vec(4'(k % 3));
      rq[k] = 1'b0;
      cyc_n(3);
    end
  endtask
  task t_levels;
    base = 16'h0400;
    ext_lvl = 8'h01;
    rq = 25'h1000001;
    cyc_n(4);
    win(SRC_T2_CMP, 16'h002c, 2'h2);
    interrupt_priority_level = 2'h2;
    rq[24] = 1'b0;
    cyc_n(4);
    chk({15'h0000, valid}, 16'h0000);
    ext_lvl = 8'h03;
    cyc_n(2);
    win(SRC_EXT_A, 16'h0010, 2'h2);
    ext_en = 4'he;
    cyc_n(2);
    chk({15'h0000, valid}, 16'h0000);
    interrupt_priority_level = 2'h3;
    core = 6'h20;
    cyc_n(1);
    win(SRC_NMI, 16'h000a, LVL_NMI);
    // a peripheral asking for level 3 is held to level 2, and can be masked
    core = 6'h00;
    rq = 25'h0000010;
    per_lvl = {42{1'b1}};
    interrupt_priority_level = 2'h2;
    cyc_n(1);
    win(SRC_HOST_CMD, 16'h0064, 2'h2);
    per_en = 21'h1ffffe;
    cyc_n(1);
    chk({15'h0000, valid}, 16'h0000);
    per_en = 21'h1fffff;
    per_lvl = 42'h2aaaaaaaaaa;
    rq = 25'h0000000;
    ext_en = 4'hf;
    interrupt_priority_level = 2'h0;
    cyc_n(4);
  endtask
  // with the enable low nothing moves, then the held request shows
  task t_hold;
    ce_i = 1'b0;
    core = 6'h01;
    cyc_n(3);
    chk({15'h0000, valid}, 16'h0000);
    ce_i = 1'b1;
    cyc_n(1);
    win(SRC_RESET, 16'h0000, LVL_NMI);
    core = 6'h00;
    cyc_n(1);
  endtask
  initial
  begin
    cyc_n(16);
    rst_i = 1'b0;
    cyc_n(1);
    chk({15'h0000, valid}, 16'h0000);
    chk(vec, 16'h0000);
    t_core_order;
    t_rank;
    t_levels;
    t_hold;
    report_and_stop;
  end
endmodule
